// File: rtl/wcc_exec.sv
`timescale 1ns/1ps
`include "wcc_regs.svh"
module wcc_exec (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // Instruction from decode, valid at Q1
    input  wire logic [1:0]  i_qphase,
    input  wire logic        i_instr_vld,
    input  wire logic [15:0] i_instr,
    // Core context
    input  wire logic        i_ext_set_en,
    input  wire logic [3:0]  i_bank_select,
    input  wire logic [11:0] i_fsr2_base,
    // Data memory read
    output logic             o_dmem_rd,
    output logic [11:0]      o_dmem_addr,
    input  wire logic [7:0]  i_dmem_rdata,
    // Destinations
    output logic             o_dmem_wr,
    output logic [7:0]       o_dmem_wdata,
    output logic             o_wreg_wr,
    output logic [7:0]       o_wreg_wdata,
    // Status flag updates
    output logic             o_nz_wr,
    output logic             o_negative_flag,
    output logic             o_zero_flag,
    output logic             o_tp_wr,
    output logic             o_timeout_flag,
    output logic             o_powerdown_flag,
    // Watchdog
    output logic             o_wdt_clear,
    output logic             o_wdt_post_clear,
    // Instruction completion
    output logic             o_done
);
    wcc_pkg::wcc_op_e   op_r, op_nxt;
    logic               dest_r, dest_nxt;
    wcc_pkg::wcc_addr_t addr_r, addr_nxt;
    wcc_pkg::wcc_byte_t res_r, res_nxt;
    logic               rd_r, rd_nxt;
    logic               dwr_r, dwr_nxt;
    logic               wwr_r, wwr_nxt;
    logic               nzw_r, nzw_nxt;
    logic               neg_r, neg_nxt;
    logic               zer_r, zer_nxt;
    logic               tpw_r, tpw_nxt;
    logic               tpv_r, tpv_nxt;
    logic               wdc_r, wdc_nxt;
    logic               done_r, done_nxt;
    logic [7:0]         fa;

    assign fa = i_instr[7:0];

    // Decode at Q1, read Q2, process Q3, write Q4
    always_comb begin
        op_nxt   = op_r;
        dest_nxt = dest_r;
        addr_nxt = addr_r;
        res_nxt  = res_r;
        rd_nxt   = 1'b0;
        dwr_nxt  = 1'b0;
        wwr_nxt  = 1'b0;
        nzw_nxt  = 1'b0;
        neg_nxt  = neg_r;
        zer_nxt  = zer_r;
        tpw_nxt  = 1'b0;
        tpv_nxt  = tpv_r;
        wdc_nxt  = 1'b0;
        done_nxt = 1'b0;
        case (i_qphase)
            `WCC_Q_DECODE: begin
                op_nxt = wcc_pkg::WCC_OP_NONE;
                if (i_instr_vld && i_instr == `WCC_OP_WDCLR) begin
                    op_nxt = wcc_pkg::WCC_OP_WDCLR; // RULE_01
                end else if (i_instr_vld &&
                             (i_instr & `WCC_OP_COMP_MASK) == `WCC_OP_COMP_VAL) begin
                    op_nxt   = wcc_pkg::WCC_OP_COMP; // RULE_04
                    dest_nxt = i_instr[`WCC_BIT_DEST];
                    if (i_instr[`WCC_BIT_ACC]) begin
                        addr_nxt = {i_bank_select, fa}; // RULE_06
                    end else if (i_ext_set_en && fa <= `WCC_IDX_LIMIT) begin
                        addr_nxt = i_fsr2_base + {4'h0, fa}; // RULE_07
                    end else if (fa < `WCC_ACC_HI_BASE) begin
                        addr_nxt = {4'h0, fa}; // RULE_06
                    end else begin
                        addr_nxt = {`WCC_ACC_HI_BANK, fa};
                    end
                    rd_nxt = 1'b1;
                end
            end
            `WCC_Q_READ: begin
                if (op_r == wcc_pkg::WCC_OP_COMP) begin
                    res_nxt = ~i_dmem_rdata; // RULE_04
                end
            end
            `WCC_Q_PROC: begin
                if (op_r == wcc_pkg::WCC_OP_WDCLR) begin
                    wdc_nxt = 1'b1; // RULE_01 RULE_02
                    tpw_nxt = 1'b1; // RULE_03
                    tpv_nxt = 1'b1; // RULE_03
                end else if (op_r == wcc_pkg::WCC_OP_COMP) begin
                    dwr_nxt = dest_r; // RULE_05
                    wwr_nxt = ~dest_r; // RULE_05
                    nzw_nxt = 1'b1; // RULE_08
                    neg_nxt = res_r[7];
                    zer_nxt = (res_r == 8'h00);
                end
                done_nxt = (op_r != wcc_pkg::WCC_OP_NONE); // RULE_08
            end
            default: begin
                op_nxt = op_r;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            op_r   <= wcc_pkg::WCC_OP_NONE;
            dest_r <= 1'b0;
            addr_r <= `WCC_RST_ADDR;
            res_r  <= `WCC_RST_BYTE;
            rd_r   <= 1'b0;
            dwr_r  <= 1'b0;
            wwr_r  <= 1'b0;
            nzw_r  <= 1'b0;
            neg_r  <= 1'b0;
            zer_r  <= 1'b0;
            tpw_r  <= 1'b0;
            tpv_r  <= `WCC_RST_FLAG; // Both status flags read as set
            wdc_r  <= 1'b0;
            done_r <= 1'b0;
        end else begin
            op_r   <= op_nxt;
            dest_r <= dest_nxt;
            addr_r <= addr_nxt;
            res_r  <= res_nxt;
            rd_r   <= rd_nxt;
            dwr_r  <= dwr_nxt;
            wwr_r  <= wwr_nxt;
            nzw_r  <= nzw_nxt;
            neg_r  <= neg_nxt;
            zer_r  <= zer_nxt;
            tpw_r  <= tpw_nxt;
            tpv_r  <= tpv_nxt;
            wdc_r  <= wdc_nxt;
            done_r <= done_nxt;
        end
    end

    // Outputs straight from flops
    assign o_dmem_rd        = rd_r;
    assign o_dmem_addr      = addr_r;
    assign o_dmem_wr        = dwr_r;
    assign o_dmem_wdata     = res_r;
    assign o_wreg_wr        = wwr_r;
    assign o_wreg_wdata     = res_r;
    assign o_nz_wr          = nzw_r;
    assign o_negative_flag  = neg_r;
    assign o_zero_flag      = zer_r;
    assign o_tp_wr          = tpw_r;
    assign o_timeout_flag   = tpv_r; // RULE_03
    assign o_powerdown_flag = tpv_r; // RULE_03
    assign o_wdt_clear      = wdc_r;
    assign o_wdt_post_clear = wdc_r;
    assign o_done           = done_r;

    // Checks
    // Watchdog clear pulse three cycles after its decode
    a_wdclr_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_01
        (i_qphase == `WCC_Q_DECODE && i_instr_vld && i_instr == `WCC_OP_WDCLR
         && i_qphase == 2'h0) ##1 (i_qphase == `WCC_Q_READ) ##1 (i_qphase == `WCC_Q_PROC)
        |=> o_wdt_clear) else $error("watchdog clear missing");
    // Postscaler clear only with the counter clear, from a decoded clear
    a_post_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_02
        (o_wdt_clear || o_wdt_post_clear) |-> (o_wdt_clear && o_wdt_post_clear
         && $past(i_instr_vld, 3) && $past(i_instr, 3) == `WCC_OP_WDCLR
         && $past(i_qphase, 3) == `WCC_Q_DECODE))
        else $error("postscaler clear mismatch");
    // Status flags read as set whenever their strobe is up
    a_flags_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_03
        o_tp_wr |-> (o_timeout_flag && o_powerdown_flag && !o_nz_wr))
        else $error("status flags wrong");
    // Result register is the inverse of the byte read in Q2
    a_comp_value: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_04
        (op_r == wcc_pkg::WCC_OP_COMP && i_qphase == `WCC_Q_READ)
        |=> res_r == ~$past(i_dmem_rdata)) else $error("complement wrong");
    // Read strobe only in Q2, after a decoded instruction
    a_read_strobe: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_04
        o_dmem_rd |-> (i_qphase == `WCC_Q_READ && $past(i_instr_vld)))
        else $error("read strobe out of place");
    // Ignored opcodes raise no read and no write
    a_refused_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_04
        (i_qphase == `WCC_Q_DECODE && !(i_instr_vld && (i_instr == `WCC_OP_WDCLR
         || (i_instr & `WCC_OP_COMP_MASK) == `WCC_OP_COMP_VAL)))
        |=> !o_dmem_rd ##2 !(o_done || o_dmem_wr || o_wreg_wr || o_wdt_clear))
        else $error("ignored opcode acted");
    // Only one destination written
    a_dest_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_05
        !(o_dmem_wr && o_wreg_wr)) else $error("two destinations");
    // Banked address from the bank select value
    a_bank_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_06
        (i_qphase == `WCC_Q_DECODE && i_instr_vld && i_instr[15:10] == 6'h07
         && i_instr[8]) |=> o_dmem_addr == {$past(i_bank_select), $past(i_instr[7:0])})
        else $error("banked address wrong");
    // Access bank address below and above the split point
    a_access_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_06
        (i_qphase == `WCC_Q_DECODE && i_instr_vld && i_instr[15:10] == 6'h07
         && !i_instr[8] && !(i_ext_set_en && i_instr[7:0] <= 8'h5F))
        |=> o_dmem_addr == {(($past(i_instr[7:0]) < `WCC_ACC_HI_BASE) ? 4'h0
                             : `WCC_ACC_HI_BANK), $past(i_instr[7:0])})
        else $error("access bank address wrong");
    // Indexed literal offset from the index base
    a_idx_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_07
        (i_qphase == `WCC_Q_DECODE && i_instr_vld && i_instr[15:10] == 6'h07
         && !i_instr[8] && i_ext_set_en && i_instr[7:0] <= 8'h5F)
        |=> o_dmem_addr == $past(i_fsr2_base) + {4'h0, $past(i_instr[7:0])})
        else $error("indexed address wrong");
    // Negative and zero flags follow the result
    a_nz_flags: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_08
        o_nz_wr |-> (o_negative_flag == o_dmem_wdata[7]
                     && o_zero_flag == (o_dmem_wdata == 8'h00) && o_done))
        else $error("N or Z wrong");
    // Completion pulse only in Q4 of a decoded instruction
    a_done_timing: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_08
        o_done |-> (i_qphase == `WCC_Q_WRITE && $past(i_qphase, 3) == `WCC_Q_DECODE
                    && $past(i_instr_vld, 3)))
        else $error("completion out of place");
endmodule

// File: shared/wcc_regs.svh
// Functional notes
// RULE_01: Opcode 0x0004 clears the watchdog counter to zero.
// RULE_02: Watchdog clear also zeroes the watchdog postscaler.
// RULE_03: Watchdog clear sets timeout and powerdown flags; other status untouched.
// RULE_04: Opcode 0001 11da ffff ffff inverts every bit of addressed byte.
// RULE_05: Destination bit zero writes working register, one writes file byte.
// RULE_06: Access bit zero uses access bank, one uses bank select register.
// RULE_07: Extended set, access zero, address at most 95 uses indexed literal offset.
// RULE_08: Complement updates negative and zero flags; both take one word, one cycle.
`ifndef WCC_REGS_SVH
`define WCC_REGS_SVH
`define WCC_OP_WDCLR      16'h0004
`define WCC_OP_COMP_MASK  16'hFC00
`define WCC_OP_COMP_VAL   16'h1C00
`define WCC_BIT_DEST      9
`define WCC_BIT_ACC       8
`define WCC_IDX_LIMIT     8'h5F
`define WCC_ACC_HI_BASE   8'h60
`define WCC_ACC_HI_BANK   4'hF
`define WCC_Q_DECODE      2'h0
`define WCC_Q_READ        2'h1
`define WCC_Q_PROC        2'h2
`define WCC_Q_WRITE       2'h3
`define WCC_RST_FLAG      1'h1
`define WCC_RST_BYTE      8'h00
`define WCC_RST_ADDR      12'h000
`endif

// File: shared/wcc_pkg.sv
package wcc_pkg;
    typedef enum logic [1:0] {
        WCC_OP_NONE,
        WCC_OP_WDCLR,
        WCC_OP_COMP
    } wcc_op_e;
    typedef logic [11:0] wcc_addr_t;
    typedef logic [7:0]  wcc_byte_t;
endpackage

// File: dv/tb_watchdog_clear_and_complement_exec.sv
`timescale 1ns/1ps
module tb_watchdog_clear_and_complement_exec;
    // Stimulus
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [1:0]  i_qphase = 2'h0;
    logic        i_instr_vld = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic        i_ext_set_en = 1'b0;
    logic [3:0]  i_bank_select = 4'h0;
    logic [11:0] i_fsr2_base = 12'h000;
    logic [7:0]  i_dmem_rdata = 8'h00;
    // Observed outputs and captures
    logic        o_dmem_rd, o_dmem_wr, o_wreg_wr, o_nz_wr, o_negative_flag, o_zero_flag;
    logic        o_tp_wr, o_timeout_flag, o_powerdown_flag, o_wdt_clear, o_wdt_post_clear;
    logic        o_done, c_rd, c_quiet;
    logic [11:0] o_dmem_addr, c_addr;
    logic [7:0]  o_dmem_wdata, o_wreg_wdata;
    int          n_fail = 0;
    int          comparisons = 0;

    wcc_exec uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_qphase(i_qphase),
        .i_instr_vld(i_instr_vld), .i_instr(i_instr), .i_ext_set_en(i_ext_set_en),
        .i_bank_select(i_bank_select), .i_fsr2_base(i_fsr2_base), .o_dmem_rd(o_dmem_rd),
        .o_dmem_addr(o_dmem_addr), .i_dmem_rdata(i_dmem_rdata), .o_dmem_wr(o_dmem_wr),
        .o_dmem_wdata(o_dmem_wdata), .o_wreg_wr(o_wreg_wr), .o_wreg_wdata(o_wreg_wdata),
        .o_nz_wr(o_nz_wr), .o_negative_flag(o_negative_flag), .o_zero_flag(o_zero_flag),
        .o_tp_wr(o_tp_wr), .o_timeout_flag(o_timeout_flag),
        .o_powerdown_flag(o_powerdown_flag), .o_wdt_clear(o_wdt_clear),
        .o_wdt_post_clear(o_wdt_post_clear), .o_done(o_done));

    // Clock and free-running Q phase
    initial forever #2 i_mclk = ~i_mclk;
    always @(posedge i_mclk) i_qphase <= i_qphase + 2'h1;

    task automatic finish_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One instruction over a full Q1..Q4 sequence, ends inside the Q4 cycle
    task automatic exec(input logic [15:0] op, input logic ext, input logic [3:0] bank,
                        input logic [11:0] base, input logic [7:0] rd);
        int n;
        n = 0;
        while (i_qphase !== 2'h3) begin
            @(posedge i_mclk);
            #1;
            n++;
            if (n > 8) begin
                n_fail++;
                finish_test();
            end
        end
        @(posedge i_mclk);
        i_instr <= op;
        i_instr_vld <= 1'b1;
        i_ext_set_en <= ext;
        i_bank_select <= bank;
        i_fsr2_base <= base;
        @(posedge i_mclk);
        i_instr_vld <= 1'b0;
        i_instr <= ~op;
        i_dmem_rdata <= rd;
        #1;
        c_rd = o_dmem_rd;
        c_addr = o_dmem_addr;
        @(posedge i_mclk);
        i_dmem_rdata <= ~rd;
        #1;
        c_quiet = !(o_done | o_dmem_wr | o_wreg_wr | o_wdt_clear);
        @(posedge i_mclk);
        #1;
    endtask

    task automatic comp_case(input logic d, input logic a, input logic ext, input logic [3:0] bank,
                             input logic [7:0] f, input logic [11:0] base, input logic [7:0] rd,
                             input logic [11:0] exp_addr);
        logic [7:0] r;
        r = ~rd;
        exec({6'b000111, d, a, f}, ext, bank, base, rd);
        cmp("dmem_rd", 16'h0001, c_rd);
        cmp("dmem_addr", exp_addr, c_addr);
        cmp("early", 16'h0001, c_quiet);
        cmp("dmem_wdata", r, o_dmem_wdata);
        cmp("wreg_wdata", r, o_wreg_wdata);
        cmp("wr_dest", {d, !d}, {o_dmem_wr, o_wreg_wr});
        cmp("nz", {1'b1, r[7], r == 8'h00}, {o_nz_wr, o_negative_flag, o_zero_flag});
        cmp("done", 16'h0001, o_done);
        cmp("wdt_idle", 16'h0000, {o_wdt_clear, o_wdt_post_clear, o_tp_wr});
    endtask

    task automatic t_clear();
        exec(16'h0004, 1'b0, 4'h0, 12'h000, 8'h00);
        cmp("wdt", 16'h0003, {o_wdt_clear, o_wdt_post_clear});
        cmp("tp", 16'h0007, {o_tp_wr, o_timeout_flag, o_powerdown_flag});
        cmp("others", 16'h0000, {o_nz_wr, o_dmem_wr, o_wreg_wr});
        cmp("done", 16'h0001, {c_quiet & o_done});
    endtask

    // Access bank and banked addressing, back to back
    task automatic t_access();
        comp_case(1'b0, 1'b0, 1'b0, 4'h5, 8'h13, 12'h000, 8'h13, 12'h013);
        comp_case(1'b1, 1'b0, 1'b0, 4'h5, 8'h60, 12'h000, 8'h00, 12'hF60);
        comp_case(1'b1, 1'b1, 1'b0, 4'h5, 8'hA0, 12'h000, 8'hFF, 12'h5A0);
        comp_case(1'b0, 1'b1, 1'b1, 4'hA, 8'h10, 12'h800, 8'h5A, 12'hA10);
    endtask

    // Indexed literal offset at the 0x5F boundary, with wrap
    task automatic t_indexed();
        comp_case(1'b1, 1'b0, 1'b1, 4'h3, 8'h5F, 12'hFF0, 8'h80, 12'h04F);
        comp_case(1'b0, 1'b0, 1'b1, 4'h3, 8'h60, 12'hFF0, 8'h7F, 12'hF60);
        comp_case(1'b0, 1'b0, 1'b0, 4'h3, 8'h5F, 12'hFF0, 8'hC3, 12'h05F);
    endtask

    // Mid-run reset clears pulses, N, Z and the held address
    task automatic t_reset();
        exec(16'h1F42, 1'b0, 4'h2, 12'h000, 8'h0F);
        cmp("pre_rst", 16'h0242, o_dmem_addr);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        @(posedge i_mclk);
        #1;
        cmp("rst_addr", 16'h0000, {o_dmem_addr, o_negative_flag, o_zero_flag});
        cmp("rst_pulse", 16'h0000, {o_dmem_rd, o_dmem_wr, o_wreg_wr, o_nz_wr, o_done});
        cmp("rst_wdt", 16'h0000, {o_wdt_clear, o_wdt_post_clear, o_tp_wr});
        cmp("rst_tp", 16'h0003, {o_timeout_flag, o_powerdown_flag});
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
    endtask

    task automatic t_refuse();
        exec(16'h1BFF, 1'b0, 4'h1, 12'h000, 8'h11);
        cmp("ignored", 16'h0000, {c_rd, o_done, o_dmem_wr, o_wreg_wr, o_nz_wr});
        exec(16'h0005, 1'b0, 4'h1, 12'h000, 8'h11);
        cmp("ignored", 16'h0000, {o_done, o_wdt_clear, o_tp_wr});
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        t_clear();
        t_access();
        t_indexed();
        t_reset();
        t_refuse();
        t_clear();
        finish_test();
    end
endmodule
